// File: aisp_consts.svh
// Constants for the converter input selection block
`ifndef AISP_CONSTS_SVH
`define AISP_CONSTS_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define AISP_NUM_INPUTS 13
`define AISP_DATA_W 16
`define AISP_ADDR_W 4

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define AISP_REG_CHAN0 4'h0
`define AISP_REG_SCAN 4'h1
`define AISP_REG_PINCFG 4'h2
`define AISP_REG_CTRL 4'h3
`define AISP_REG_STATUS 4'h4

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define AISP_RST_REG 16'h0000
`define AISP_RST_CODE 5'h00
`define AISP_RST_MASK 13'h0000
`define AISP_MASK_IMPL 16'h1FFF
`define AISP_SEL_A_LSB 0
`define AISP_SEL_B_LSB 8
`define AISP_CTRL_ALT 0
`define AISP_CTRL_SCAN 1
`define AISP_CTRL_DIS 2
`define AISP_STAT_PHASE 8

// ----------------------------------------------------------------
// Selector codes and input presence
// ----------------------------------------------------------------
`define AISP_MAX_CODE 5'h0C
`define AISP_RSV_LO 5'h06
`define AISP_RSV_HI 5'h08
`define AISP_LAST_INPUT 4'hC
`define AISP_FIRST_INPUT 4'h0
`define AISP_FULL_PRESENT 13'h1FFF
`define AISP_SMALL_PRESENT 13'h1E3F

`endif

// File: aisp_pkg.sv
// Types shared by the converter input selection block
package aisp_pkg;

	// ------------------------------------------------------------
	// Sample phase of channel 0
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		AISP_PH_A = 1'b0,
		AISP_PH_B = 1'b1
	} aisp_phase_t;

	typedef logic [12:0] aisp_mask_t;
	typedef logic [4:0] aisp_code_t;

endpackage : aisp_pkg

// File: aisp_scan_next.sv
// Finds the first included scan input at or above a start index, else the lowest included one
`timescale 1ns/1ns
`include "aisp_consts.svh"

module aisp_scan_next
	import aisp_pkg::*;
#(
	parameter int N = `AISP_NUM_INPUTS
) (
	input wire logic [N-1:0] mask,
	input wire logic [3:0] start,
	output logic [3:0] found,
	output logic any
);

	logic [3:0] hi;
	logic [3:0] lo;
	logic hv;

	// Lowest set bit overall and lowest at or above start
	always_comb begin
		hi = `AISP_FIRST_INPUT;
		lo = `AISP_FIRST_INPUT;
		hv = 1'b0;
		any = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (mask[i]) begin
				lo = 4'(i);
				any = 1'b1;
				if (4'(i) >= start) begin
					hi = 4'(i);
					hv = 1'b1;
				end
			end
		end
		found = hv ? hi : lo;
	end

endmodule : aisp_scan_next

// File: aisp_pin_route.sv
// Per-pin analog or digital routing of the shared input pins
`timescale 1ns/1ns
`include "aisp_consts.svh"

module aisp_pin_route
	import aisp_pkg::*;
#(
	parameter int N = `AISP_NUM_INPUTS,
	parameter logic [N-1:0] PRESENT = `AISP_FULL_PRESENT
) (
	input wire logic [N-1:0] pin_digital_select,
	input wire logic converter_module_disable,
	output logic [N-1:0] pin_digital,
	output logic [N-1:0] port_read_en,
	output logic [N-1:0] mux_to_ground
);

	genvar k;

	// ------------------------------------------------------------
	// One routing slice per analog input
	// ------------------------------------------------------------
	generate
		for (k = 0; k < N; k++) begin : g_pin
			logic dig;
			// Disabled converter forces digital; absent pins stay idle
			assign dig = PRESENT[k] &&
				(converter_module_disable || pin_digital_select[k]);
			assign pin_digital[k] = dig;
			assign port_read_en[k] = dig;
			assign mux_to_ground[k] = dig;
		end
	endgenerate

endmodule : aisp_pin_route

// File: aisp_top.sv
// Channel 0 input selection, scan mask and pin configuration
// What this block does
// - Sample-A code n selects analog input n, codes 0 through 12.
// - Small variant: codes 6, 7 and 8 are reserved, select nothing.
// - Set scan bit includes that input in scanning, clear bit skips it.
// - Scan bits always writable; scanning an absent input converts low reference.
// - Bits 15 to 13 of scan and pin registers read as zero.
// - Set pin bit: digital mode, port read on, multiplexer tied to ground.
// - Clear pin bit: analog mode, port read off, pin voltage sampled.
// - All pin bits writable; bits of absent inputs affect no pin.
// - Converter disabled: pin bits ignored, all shared pins digital.
// - Sample-B selector uses the same code, applied in the B phase.
// - Alternate mode: A then B selections in turn; otherwise always A.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "aisp_consts.svh"

module aisp_top
	import aisp_pkg::*;
#(
	parameter logic SMALL_PKG = 1'b0
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic [`AISP_ADDR_W-1:0] ADDR,
	input wire logic [`AISP_DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [`AISP_DATA_W-1:0] RDATA,
	input wire logic SAMPLE_DONE,
	output logic [4:0] CH0_POS_SEL,
	output logic CH0_SEL_VALID,
	output logic CH0_LOW_REF,
	output logic SAMPLE_PHASE_B,
	output logic [`AISP_NUM_INPUTS-1:0] PIN_DIGITAL,
	output logic [`AISP_NUM_INPUTS-1:0] PORT_READ_EN,
	output logic [`AISP_NUM_INPUTS-1:0] MUX_TO_GROUND
);

	localparam int N = `AISP_NUM_INPUTS;
	localparam logic [N-1:0] PRESENT =
		SMALL_PKG ? `AISP_SMALL_PRESENT : `AISP_FULL_PRESENT;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	aisp_code_t chan0_positive_select_a;
	aisp_code_t chan0_positive_select_b;
	aisp_mask_t input_scan_select;
	aisp_mask_t analog_pin_config;
	logic alternate_sample_mode;
	logic scan_enable;
	logic converter_module_disable;
	aisp_phase_t phase;
	aisp_phase_t next_phase;
	logic [3:0] scan_pos;
	logic [3:0] next_scan_pos;
	logic [3:0] scan_found;
	logic scan_any;
	logic scan_on;
	logic scan_step;
	aisp_code_t eff_code;
	logic code_ok;
	logic [`AISP_DATA_W-1:0] next_rdata;

	logic wr_chan0;
	logic wr_scan;
	logic wr_pincfg;
	logic wr_ctrl;

	assign wr_chan0 = WR && (ADDR == `AISP_REG_CHAN0);
	assign wr_scan = WR && (ADDR == `AISP_REG_SCAN);
	assign wr_pincfg = WR && (ADDR == `AISP_REG_PINCFG);
	assign wr_ctrl = WR && (ADDR == `AISP_REG_CTRL);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			chan0_positive_select_a <= `AISP_RST_CODE;
			chan0_positive_select_b <= `AISP_RST_CODE;
		end else if (wr_chan0) begin
			chan0_positive_select_a <=
				WDATA[`AISP_SEL_A_LSB +: 5];
			chan0_positive_select_b <=
				WDATA[`AISP_SEL_B_LSB +: 5];
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			input_scan_select <= `AISP_RST_MASK;
		end else if (wr_scan) begin
			input_scan_select <= WDATA[N-1:0];
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			analog_pin_config <= `AISP_RST_MASK;
		end else if (wr_pincfg) begin
			analog_pin_config <= WDATA[N-1:0];
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			alternate_sample_mode <= 1'b0;
			scan_enable <= 1'b0;
			converter_module_disable <= 1'b0;
		end else if (wr_ctrl) begin
			alternate_sample_mode <= WDATA[`AISP_CTRL_ALT];
			scan_enable <= WDATA[`AISP_CTRL_SCAN];
			converter_module_disable <= WDATA[`AISP_CTRL_DIS];
		end
	end

	// ------------------------------------------------------------
	// Sample phase and scan pointer
	// ------------------------------------------------------------
	assign scan_on = scan_enable && !converter_module_disable;
	assign scan_step = SAMPLE_DONE && scan_on && (phase == AISP_PH_A);

	aisp_scan_next #(
		.N(N)
	) u_scan_next (
		.mask(input_scan_select),
		.start(scan_pos),
		.found(scan_found),
		.any(scan_any)
	);

	always_comb begin
		case (phase)
			AISP_PH_A: next_phase = alternate_sample_mode ?
				AISP_PH_B : AISP_PH_A;
			AISP_PH_B: next_phase = AISP_PH_A;
			default: next_phase = AISP_PH_A;
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			phase <= AISP_PH_A;
		end else if (!alternate_sample_mode) begin
			phase <= AISP_PH_A;
		end else if (SAMPLE_DONE) begin
			phase <= next_phase;
		end
	end

	// Advance past the input just converted, wrapping after the last
	always_comb begin
		if (scan_found == `AISP_LAST_INPUT) begin
			next_scan_pos = `AISP_FIRST_INPUT;
		end else begin
			next_scan_pos = 4'(scan_found + 4'h1);
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			scan_pos <= `AISP_FIRST_INPUT;
		end else if (scan_step && scan_any) begin
			scan_pos <= next_scan_pos;
		end
	end

	// ------------------------------------------------------------
	// Channel 0 positive input
	// ------------------------------------------------------------
	always_comb begin
		if (phase == AISP_PH_B) begin
			eff_code = chan0_positive_select_b;
		end else if (scan_on) begin
			eff_code = {1'b0, scan_found};
		end else begin
			eff_code = chan0_positive_select_a;
		end
	end

	assign code_ok = (eff_code <= `AISP_MAX_CODE) &&
		!(SMALL_PKG && (eff_code >= `AISP_RSV_LO) &&
		(eff_code <= `AISP_RSV_HI));

	assign CH0_POS_SEL = eff_code;
	assign SAMPLE_PHASE_B = (phase == AISP_PH_B);

	always_comb begin
		CH0_SEL_VALID = 1'b0;
		CH0_LOW_REF = 1'b0;
		if (converter_module_disable) begin
			CH0_SEL_VALID = 1'b0;
		end else if (scan_on && (phase == AISP_PH_A)) begin
			CH0_SEL_VALID = scan_any;
			CH0_LOW_REF = scan_any && !PRESENT[scan_found];
		end else begin
			CH0_SEL_VALID = code_ok;
		end
	end

	// ------------------------------------------------------------
	// Pin routing
	// ------------------------------------------------------------
	aisp_pin_route #(
		.N(N),
		.PRESENT(PRESENT)
	) u_pin_route (
		.pin_digital_select(analog_pin_config),
		.converter_module_disable(converter_module_disable),
		.pin_digital(PIN_DIGITAL),
		.port_read_en(PORT_READ_EN),
		.mux_to_ground(MUX_TO_GROUND)
	);

	// ------------------------------------------------------------
	// Read path, data in the cycle after the strobe only
	// ------------------------------------------------------------
	always_comb begin
		next_rdata = `AISP_RST_REG;
		if (RD) begin
			case (ADDR)
				`AISP_REG_CHAN0: begin
					next_rdata[`AISP_SEL_A_LSB +: 5] =
						chan0_positive_select_a;
					next_rdata[`AISP_SEL_B_LSB +: 5] =
						chan0_positive_select_b;
				end
				`AISP_REG_SCAN: begin
					next_rdata[N-1:0] = input_scan_select;
				end
				`AISP_REG_PINCFG: begin
					next_rdata[N-1:0] = analog_pin_config;
				end
				`AISP_REG_CTRL: begin
					next_rdata[`AISP_CTRL_ALT] = alternate_sample_mode;
					next_rdata[`AISP_CTRL_SCAN] = scan_enable;
					next_rdata[`AISP_CTRL_DIS] = converter_module_disable;
				end
				`AISP_REG_STATUS: begin
					next_rdata[`AISP_SEL_A_LSB +: 5] = eff_code;
					next_rdata[`AISP_STAT_PHASE] = (phase == AISP_PH_B);
				end
				default: begin
					next_rdata = `AISP_RST_REG;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			RDATA <= `AISP_RST_REG;
		end else begin
			RDATA <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_SEL_A_WRITE: assert property (@(posedge CLK) disable iff (!NRST)
		(wr_chan0 && !scan_on && !alternate_sample_mode &&
		!converter_module_disable && !wr_ctrl) |=>
		(CH0_POS_SEL == $past(WDATA[4:0])))
		else $error("sample A code not applied after write");

	AST_RESERVED_CODE: assert property (@(posedge CLK) disable iff (!NRST)
		(SMALL_PKG && !scan_on && phase == AISP_PH_A &&
		CH0_POS_SEL >= `AISP_RSV_LO && CH0_POS_SEL <= `AISP_RSV_HI) |->
		!CH0_SEL_VALID)
		else $error("reserved code marked valid");

	AST_SCAN_INCLUDED: assert property (@(posedge CLK) disable iff (!NRST)
		(scan_on && phase == AISP_PH_A && CH0_SEL_VALID) |->
		input_scan_select[CH0_POS_SEL[3:0]])
		else $error("scan picked an excluded input");

	AST_SCAN_WRAP: assert property (@(posedge CLK) disable iff (!NRST)
		(scan_step && scan_any && !wr_scan && !wr_ctrl &&
		!alternate_sample_mode &&
		input_scan_select == aisp_mask_t'(1) << scan_found) |=>
		(CH0_POS_SEL == $past(CH0_POS_SEL)))
		else $error("single-input scan moved");

	AST_LOW_REF: assert property (@(posedge CLK) disable iff (!NRST)
		CH0_LOW_REF |-> (scan_on && !PRESENT[CH0_POS_SEL[3:0]] &&
		CH0_SEL_VALID))
		else $error("low reference outside an absent scan step");

	AST_UPPER_ZERO: assert property (@(posedge CLK) disable iff (!NRST)
		(RD && (ADDR == `AISP_REG_SCAN || ADDR == `AISP_REG_PINCFG)) |=>
		(RDATA[`AISP_DATA_W-1:N] == '0))
		else $error("unimplemented bits read nonzero");

	AST_PIN_MODE: assert property (@(posedge CLK) disable iff (!NRST)
		!converter_module_disable |->
		(PIN_DIGITAL == (analog_pin_config & PRESENT) &&
		PORT_READ_EN == PIN_DIGITAL && MUX_TO_GROUND == PIN_DIGITAL))
		else $error("pin routing disagrees with configuration");

	AST_DISABLED_DIGITAL: assert property (@(posedge CLK)
		disable iff (!NRST)
		converter_module_disable |-> (PIN_DIGITAL == PRESENT))
		else $error("disabled converter left a pin analog");

	AST_SEL_B_PHASE: assert property (@(posedge CLK) disable iff (!NRST)
		(phase == AISP_PH_B) |-> (CH0_POS_SEL == chan0_positive_select_b))
		else $error("sample B code not used in B phase");

	AST_ALT_TOGGLE: assert property (@(posedge CLK) disable iff (!NRST)
		(SAMPLE_DONE && alternate_sample_mode && !wr_ctrl) |=>
		(SAMPLE_PHASE_B != $past(SAMPLE_PHASE_B)))
		else $error("alternate mode did not toggle phase");

	AST_NO_ALT_A: assert property (@(posedge CLK) disable iff (!NRST)
		!alternate_sample_mode |=> !SAMPLE_PHASE_B)
		else $error("phase B used without alternate mode");

	AST_SCAN_WRITE: assert property (@(posedge CLK) disable iff (!NRST)
		wr_scan |=> (input_scan_select == $past(WDATA[N-1:0])))
		else $error("scan mask write not taken");

endmodule : aisp_top

// File: aisp_far_model.sv
// Far side model: converter input multiplexer and sampled level
`timescale 1ns/1ns

module aisp_far_model
	import aisp_pkg::*;
(
	input wire logic [4:0] sel,
	input wire logic sel_valid,
	input wire logic low_ref,
	input wire logic [12:0] mux_to_ground,
	output logic [7:0] sample
);
	// ------------------------------------------------------------
	// Converted level
	// ------------------------------------------------------------
	always_comb begin
		if (!sel_valid)
			sample = 8'hEE;
		else if (low_ref)
			sample = 8'h01;
		else if (mux_to_ground[sel[3:0]])
			sample = 8'h00;
		else
			sample = {3'h4, sel};
	end
endmodule : aisp_far_model

// File: tb.sv
// Testbench for the converter input selection block
`timescale 1ns/1ns
`include "aisp_consts.svh"

module tb
	import aisp_pkg::*;
;
	logic clk, nrst, wr, rd, sdone;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, rdata_s, d, ds;
	logic [4:0] sel, sel_s;
	logic vld, vld_s, lref, lref_s, phb, phb_s;
	logic [12:0] dig, dig_s, pre, pre_s, gnd, gnd_s;
	logic [7:0] conv;
	logic [35:0] rows [9];
	int mismatches, compares;

	aisp_top aisp_top_i (.CLK(clk), .NRST(nrst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.SAMPLE_DONE(sdone), .CH0_POS_SEL(sel), .CH0_SEL_VALID(vld),
		.CH0_LOW_REF(lref), .SAMPLE_PHASE_B(phb), .PIN_DIGITAL(dig),
		.PORT_READ_EN(pre), .MUX_TO_GROUND(gnd));
	aisp_top #(.SMALL_PKG(1'b1)) aisp_top_s_i (.CLK(clk), .NRST(nrst),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata_s),
		.SAMPLE_DONE(sdone), .CH0_POS_SEL(sel_s), .CH0_SEL_VALID(vld_s),
		.CH0_LOW_REF(lref_s), .SAMPLE_PHASE_B(phb_s), .PIN_DIGITAL(dig_s),
		.PORT_READ_EN(pre_s), .MUX_TO_GROUND(gnd_s));
	aisp_far_model aisp_far_model_i (.sel(sel), .sel_valid(vld),
		.low_ref(lref), .mux_to_ground(gnd), .sample(conv));

	// ------------------------------------------------------------
	// Clock and watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report();
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp,
		input string msg);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s seen %h want %h", $time, msg,
				seen, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
		ds = rdata_s;
	endtask : rd_reg

	task automatic pulse();
		@(posedge clk);
		sdone <= 1'b1;
		@(posedge clk);
		sdone <= 1'b0;
		#1;
	endtask : pulse

	task automatic reset_dut();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		#1;
	endtask : reset_dut

	task automatic check_reset();
		for (int i = 0; i < 4; i++) begin
			rd_reg(4'(i));
			check(d, 16'h0000, "reset reg");
		end
		check(sel, 5'h00, "reset sel");
		check(dig | pre | gnd, 13'h0000, "reset pins");
		$display("test reset done");
	endtask : check_reset

	task final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		sdone = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		// Address, write data, expected read back
		rows = '{{4'h1, 16'hFFFF, 16'h1FFF}, {4'h2, 16'hFFFF, 16'h1FFF},
			{4'h0, 16'hFFFF, 16'h1F1F}, {4'h3, 16'hFFFF, 16'h0007},
			{4'h5, 16'hFFFF, 16'h0000}, {4'h3, 16'h0000, 16'h0000},
			{4'h2, 16'h0000, 16'h0000}, {4'h1, 16'h0000, 16'h0000},
			{4'h0, 16'h0000, 16'h0000}};
		reset_dut();
		check_reset();
		foreach (rows[i]) begin
			wr_reg(rows[i][35:32], rows[i][31:16]);
			rd_reg(rows[i][35:32]);
			check(d, rows[i][15:0], "reg row");
			check(ds, rows[i][15:0], "small reg row");
		end
		$display("test registers done");
		for (int n = 0; n < 14; n++) begin
			wr_reg(`AISP_REG_CHAN0, 16'(n));
			if (n < 13)
				check(sel, 5'(n), "code");
			check(vld, n < 13, "valid");
			check(vld_s, n < 6 || (n > 8 && n < 13), "small valid");
		end
		$display("test codes done");
		wr_reg(`AISP_REG_PINCFG, 16'h0A55);
		check(dig, 13'h0A55, "digital");
		check(pre, 13'h0A55, "read en");
		check(gnd, 13'h0A55, "ground");
		check(dig_s, 13'h0A55 & `AISP_SMALL_PRESENT, "absent pin");
		check(pre_s, 13'h0A55 & `AISP_SMALL_PRESENT, "absent read");
		check(gnd_s, 13'h0A55 & `AISP_SMALL_PRESENT, "absent gnd");
		wr_reg(`AISP_REG_CHAN0, 16'h0003);
		check(conv, 8'h83, "analog sample");
		wr_reg(`AISP_REG_CHAN0, 16'h0002);
		check(conv, 8'h00, "grounded");
		wr_reg(`AISP_REG_CTRL, 16'h0004);
		check(dig, `AISP_FULL_PRESENT, "disabled");
		check(dig_s, `AISP_SMALL_PRESENT, "small disabled");
		check(vld, 1'b0, "disabled valid");
		wr_reg(`AISP_REG_PINCFG, 16'h0000);
		check(pre, `AISP_FULL_PRESENT, "disabled read");
		$display("test pins done");
		wr_reg(`AISP_REG_CTRL, 16'h0002);
		wr_reg(`AISP_REG_SCAN, 16'h1005);
		check(sel, 5'h00, "scan first");
		pulse();
		check(sel, 5'h02, "scan step");
		pulse();
		check(sel, 5'h0C, "scan last");
		pulse();
		check(sel, 5'h00, "scan wrap");
		wr_reg(`AISP_REG_SCAN, 16'h0080);
		check(sel_s, 5'h07, "absent scan");
		check({vld_s, lref_s}, 2'b11, "low ref");
		check({vld, lref}, 2'b10, "present");
		pulse();
		check(sel_s, 5'h07, "single scan");
		$display("test scan done");
		wr_reg(`AISP_REG_CTRL, 16'h0001);
		wr_reg(`AISP_REG_CHAN0, 16'h0803);
		check({phb, sel}, 6'h03, "alt A");
		pulse();
		check({phb, sel}, 6'h28, "alt B");
		check(vld_s, 1'b0, "small B");
		rd_reg(`AISP_REG_STATUS);
		check(d, 16'h0108, "status B");
		@(posedge clk);
		#1;
		check(rdata, 16'h0000, "read gone");
		pulse();
		check({phb, sel}, 6'h03, "alt A again");
		pulse();
		wr_reg(`AISP_REG_CTRL, 16'h0000);
		@(posedge clk);
		#1;
		check({phb, sel}, 6'h03, "alt forced A");
		pulse();
		check({phb, sel}, 6'h03, "alt off");
		$display("test alternate done");
		wr_reg(`AISP_REG_PINCFG, 16'h1FFF);
		wr_reg(`AISP_REG_CHAN0, 16'h0A05);
		reset_dut();
		check_reset();
		final_report();
	end
endmodule : tb
